// [include/irq_enable_pkg.sv]
package irq_enable_pkg;

  // widths of the control-port access and of the lane set
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int LANES  = 8;

  // register offsets on the control port
  localparam logic [ADDR_W-1:0] PLL_FIFO_MASK_ADDR  = 12'h01f;
  localparam logic [ADDR_W-1:0] PRBS_MASK_ADDR      = 12'h020;
  localparam logic [ADDR_W-1:0] LINK_A_MASK_ADDR    = 12'h021;
  localparam logic [ADDR_W-1:0] LINK_B_MASK_ADDR    = 12'h022;
  localparam logic [ADDR_W-1:0] PLL_FIFO_FLAGS_ADDR = 12'h023;
  localparam logic [ADDR_W-1:0] PRBS_FLAGS_ADDR     = 12'h024;
  localparam logic [ADDR_W-1:0] LINK_A_FLAGS_ADDR   = 12'h025;
  localparam logic [ADDR_W-1:0] LINK_B_FLAGS_ADDR   = 12'h026;
  localparam logic [ADDR_W-1:0] FIFO_FULL_ADDR      = 12'h30c;
  localparam logic [ADDR_W-1:0] FIFO_EMPTY_ADDR     = 12'h30d;

  // reset value of every enable and flag register
  localparam logic [DATA_W-1:0] MASK_RST = 8'h00;

  // bits that software may store in each enable register
  localparam logic [DATA_W-1:0] PLL_FIFO_WR_BITS = 8'hff;
  localparam logic [DATA_W-1:0] PRBS_WR_BITS     = 8'h0f;
  localparam logic [DATA_W-1:0] LINK_WR_BITS     = 8'hff;

  // bits that carry a real event in each group
  localparam logic [DATA_W-1:0] PLL_FIFO_EVT_BITS = 8'h3e;
  localparam logic [DATA_W-1:0] PRBS_EVT_BITS     = 8'h0f;
  localparam logic [DATA_W-1:0] LINK_EVT_BITS     = 8'hbf;

  // field positions
  localparam int FIFO_FAULT_BIT = 1;
  localparam int PLL_EVT_LSB    = 2;

  // detector pulses entering the block
  typedef struct packed {
    logic [3:0]       pll;        // {dac lost, dac lock, ser lost, ser lock}
    logic [LANES-1:0] lane_full;
    logic [LANES-1:0] lane_empty;
    logic [3:0]       prbs;       // {b imag, b real, a imag, a real}
    logic [7:0]       link_a;     // same layout as its enable register
    logic [7:0]       link_b;
  } event_in_t;

  // one decoded control-port access
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  typedef enum logic {LINK_DOWN, LINK_UP} link_state_t;

endpackage

// [verif/event_irq_chk.sv]
`timescale 1ns/1ns
module event_irq_chk (
  // clock and reset
  input wire logic                              mclk,
  input wire logic                              resetn,
  // register port
  input wire irq_enable_pkg::reg_req_t          req,
  input wire logic [irq_enable_pkg::DATA_W-1:0] rdata_r,
  input wire logic                              rvalid_r,
  // events, link control, request
  input wire irq_enable_pkg::event_in_t         events,
  input wire logic                              link_en,
  input wire logic                              irq_r
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // read answer and held data
  a_read_answer: assert property (1'b1 |=> rvalid_r == $past(req.rd))
    else $error("read answer out of step");
  a_rdata_holds: assert property (!rvalid_r |-> $stable(rdata_r))
    else $error("read data moved without a read");
  a_reserved_zero: assert property (req.rd && (req.addr == 12'h020 || req.addr == 12'h024)
    |=> rdata_r[7:4] == 4'h0) else $error("reserved bits read nonzero");
  // request only rises after an event or a write
  a_irq_cause: assert property ($rose(irq_r) |-> $past(req.wr) || $past(req.wr, 2)
    || $past(|events) || $past(|events, 2)) else $error("request rose without cause");
  a_irq_keep: assert property (irq_r && !$past(req.wr) && $past(link_en)
    && $past(link_en, 2) |=> irq_r) else $error("request dropped without cause");
  a_irq_fall: assert property ($fell(irq_r) |-> $past(req.wr) || $past(req.wr, 2)
    || ($past(link_en, 2) && !$past(link_en, 3))) else $error("request fell without cause");
  a_reset_quiet: assert property ($rose(resetn) |-> !irq_r && !rvalid_r
    && rdata_r == 8'h00 ##1 !irq_r) else $error("outputs busy after reset");
  // a full lane stays latched while the link stays up
  a_lane_latch: assert property (req.rd && req.addr == 12'h30c && link_en
    && $past(link_en) |=> (rdata_r & $past(events.lane_full, 2)) == $past(events.lane_full, 2))
    else $error("lane full latch lost");
endmodule

// [verif/test_event_interrupt_enables.sv]
`timescale 1ns/1ns
module test_event_interrupt_enables;
  typedef struct packed {logic [11:0] a; logic [7:0] w; logic [7:0] r;} row_t;
  logic                              mclk = 1'b0;
  logic                              resetn = 1'b0;
  logic                              link_en = 1'b1;
  irq_enable_pkg::reg_req_t          rq = '0;
  irq_enable_pkg::event_in_t         ev = '0;
  logic [irq_enable_pkg::DATA_W-1:0] rdata_r;
  logic                              rvalid_r;
  logic                              irq_r;
  int                                fails = 0;
  int                                samples_checked = 0;
  int                                cyc = 0;
  // address, data written, value read back
  row_t rows [6] = '{'{12'h01f, 8'hff, 8'hff}, '{12'h020, 8'hff, 8'h0f},
    '{12'h021, 8'hff, 8'hff}, '{12'h022, 8'ha5, 8'ha5}, '{12'h100, 8'hff, 8'h00},
    '{12'h30c, 8'hff, 8'h00}};
  // clock
  initial forever #4 mclk = ~mclk;
  event_interrupt_enables i_dut (
    .mclk     (mclk),
    .resetn   (resetn),
    .req      (rq),
    .rdata_r  (rdata_r),
    .rvalid_r (rvalid_r),
    .events   (ev),
    .link_en  (link_en),
    .irq_r    (irq_r)
  );
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // one access, then an idle cycle
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    rq = '{1'b1, 1'b0, a, d};
    @(negedge mclk);
    rq = '0;
    @(negedge mclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    rq = '{1'b0, 1'b1, a, 8'h00};
    @(negedge mclk);
    rq = '0;
    chk({7'h0, rvalid_r}, 8'h01);
    chk(rdata_r, e);
    @(negedge mclk);
  endtask
  // one-cycle event pulse, returns when the request has settled
  task automatic fire(input int g, input int b);
    case (g)
      0: ev.prbs[b] = 1'b1;
      1: ev.link_a[b] = 1'b1;
      2: ev.lane_full[b] = 1'b1;
      3: ev.lane_empty[b] = 1'b1;
      4: ev.pll[b] = 1'b1;
      default: ev.link_b[b] = 1'b1;
    endcase
    @(negedge mclk);
    ev = '0;
    @(negedge mclk);
  endtask
  task automatic do_reset;
    resetn = 1'b0;
    repeat (6) @(negedge mclk);
    resetn = 1'b1;
    @(negedge mclk);
  endtask
  // hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      tally_and_finish();
    end
  end
  initial begin
    do_reset();
    for (int i = 0; i < 4; i++) rd(12'h01f + 12'(i), 8'h00);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].r);
    end
    // one enable at a time: neighbour masked, own bit raises except link a bit 6, flags clear
    for (int g = 0; g < 2; g++) begin
      for (int b = 0; b < 8; b++) begin
        if (g == 0 && b > 3) continue;
        wr(12'h020 + 12'(g), 8'h01 << b);
        fire(g, b ^ 1);
        chk({7'h0, irq_r}, 8'h00);
        fire(g, b);
        chk({7'h0, irq_r}, {7'h0, b != 6});
        rd(12'h024 + 12'(g), (8'h03 << (b & 6)) & (g ? 8'hbf : 8'h0f));
        wr(12'h024 + 12'(g), 8'hff);
        chk({7'h0, irq_r}, 8'h00);
      end
      wr(12'h020 + 12'(g), 8'h00);
    end
    // lane fault stays until the link is cycled
    wr(12'h01f, 8'h02);
    fire(2, 3);
    chk({7'h0, irq_r}, 8'h01);
    fire(3, 5);
    rd(12'h30c, 8'h08);
    rd(12'h30d, 8'h20);
    wr(12'h023, 8'h02);
    chk({7'h0, irq_r}, 8'h01);
    link_en = 1'b0;
    @(negedge mclk);
    link_en = 1'b1;
    repeat (2) @(negedge mclk);
    chk({7'h0, irq_r}, 8'h00);
    rd(12'h30c, 8'h00);
    // pll lock flag through its enable, then cleared
    wr(12'h01f, 8'h3c);
    fire(4, 0);
    chk({7'h0, irq_r}, 8'h01);
    rd(12'h023, 8'h04);
    wr(12'h023, 8'hff);
    chk({7'h0, irq_r}, 8'h00);
    // link b amp fault with its enable still set
    fire(5, 7);
    chk({7'h0, irq_r}, 8'h01);
    rd(12'h026, 8'h80);
    wr(12'h026, 8'hff);
    chk({7'h0, irq_r}, 8'h00);
    // reset in mid-run clears enables
    wr(12'h021, 8'hff);
    do_reset();
    rd(12'h021, 8'h00);
    tally_and_finish();
  end
endmodule
bind event_interrupt_enables event_irq_chk i_chk (.mclk(mclk), .resetn(resetn), .req(req),
  .rdata_r(rdata_r), .rvalid_r(rvalid_r), .events(events), .link_en(link_en), .irq_r(irq_r));

// [verilog/event_interrupt_enables.sv]
`timescale 1ns/1ns
module event_interrupt_enables (
  // clock and reset
  input  wire logic                             mclk,
  input  wire logic                             resetn,
  // control-port register access
  input  wire irq_enable_pkg::reg_req_t         req,
  output logic      [irq_enable_pkg::DATA_W-1:0] rdata_r,
  output logic                                  rvalid_r,
  // detector events and link control
  input  wire irq_enable_pkg::event_in_t        events,
  input  wire logic                             link_en,
  // interrupt request
  output logic                                  irq_r
);

  logic [irq_enable_pkg::DATA_W-1:0] pll_fifo_interrupt_mask_r;
  logic [irq_enable_pkg::DATA_W-1:0] prbs_check_interrupt_mask_r;
  logic [irq_enable_pkg::DATA_W-1:0] link_a_event_interrupt_mask_r;
  logic [irq_enable_pkg::DATA_W-1:0] link_b_event_interrupt_mask_r;
  logic [irq_enable_pkg::DATA_W-1:0] pll_flags;
  logic [irq_enable_pkg::DATA_W-1:0] prbs_check_event_flags;
  logic [irq_enable_pkg::DATA_W-1:0] link_a_flags;
  logic [irq_enable_pkg::DATA_W-1:0] link_b_flags;
  logic [irq_enable_pkg::DATA_W-1:0] pll_fifo_status;
  logic [irq_enable_pkg::DATA_W-1:0] pll_set;
  logic [irq_enable_pkg::DATA_W-1:0] prbs_set;
  logic [irq_enable_pkg::LANES-1:0]  full_seen;
  logic [irq_enable_pkg::LANES-1:0]  empty_seen;
  logic                              fifo_fault;
  logic                              fifo_fault_irq_on;
  logic                              irq_nxt;
  logic [irq_enable_pkg::DATA_W-1:0] rdata_nxt;

  // write strobe for one address
  function automatic logic wr_hit(input irq_enable_pkg::reg_req_t r,
                                  input logic [irq_enable_pkg::ADDR_W-1:0] a);
    wr_hit = r.wr && (r.addr == a);
  endfunction

  // write-one-to-clear vector for a flag register
  function automatic logic [irq_enable_pkg::DATA_W-1:0] w1c(
      input irq_enable_pkg::reg_req_t r,
      input logic [irq_enable_pkg::ADDR_W-1:0] a);
    w1c = wr_hit(r, a) ? r.wdata : '0;
  endfunction

  // any flag that its enable lets through
  function automatic logic pending(input logic [irq_enable_pkg::DATA_W-1:0] f,
                                   input logic [irq_enable_pkg::DATA_W-1:0] en,
                                   input logic [irq_enable_pkg::DATA_W-1:0] evt);
    pending = |(f & en & evt);
  endfunction

  // lane fifo fault detection and per-lane latches
  lane_fifo_monitor u_lane_mon (
    .mclk       (mclk),
    .resetn     (resetn),
    .lane_full  (events.lane_full),
    .lane_empty (events.lane_empty),
    .link_en    (link_en),
    .full_seen  (full_seen),
    .empty_seen (empty_seen),
    .fifo_fault (fifo_fault)
  );

  // event vectors placed at their enable positions
  assign pll_set  = {2'b00, events.pll, 2'b00};
  assign prbs_set = {4'h0, events.prbs};

  // pll lock and lost flags
  sticky_flag_bank #(.WIDTH(irq_enable_pkg::DATA_W)) u_pll_flags (
    .mclk   (mclk),
    .resetn (resetn),
    .set_in (pll_set & irq_enable_pkg::PLL_FIFO_EVT_BITS),
    .clr_in (w1c(req, irq_enable_pkg::PLL_FIFO_FLAGS_ADDR)),
    .flags  (pll_flags)
  );

  // prbs check error flags
  sticky_flag_bank #(.WIDTH(irq_enable_pkg::DATA_W)) u_prbs_flags (
    .mclk   (mclk),
    .resetn (resetn),
    .set_in (prbs_set),
    .clr_in (w1c(req, irq_enable_pkg::PRBS_FLAGS_ADDR)),
    .flags  (prbs_check_event_flags)
  );

  // link a event flags
  sticky_flag_bank #(.WIDTH(irq_enable_pkg::DATA_W)) u_link_a_flags (
    .mclk   (mclk),
    .resetn (resetn),
    .set_in (events.link_a & irq_enable_pkg::LINK_EVT_BITS),
    .clr_in (w1c(req, irq_enable_pkg::LINK_A_FLAGS_ADDR)),
    .flags  (link_a_flags)
  );

  // link b event flags
  sticky_flag_bank #(.WIDTH(irq_enable_pkg::DATA_W)) u_link_b_flags (
    .mclk   (mclk),
    .resetn (resetn),
    .set_in (events.link_b & irq_enable_pkg::LINK_EVT_BITS),
    .clr_in (w1c(req, irq_enable_pkg::LINK_B_FLAGS_ADDR)),
    .flags  (link_b_flags)
  );

  // fifo fault ignores write-one-to-clear; only the link cycle clears it
  always_comb begin
    pll_fifo_status = pll_flags & irq_enable_pkg::PLL_FIFO_EVT_BITS;
    pll_fifo_status[irq_enable_pkg::FIFO_FAULT_BIT] = fifo_fault;
  end

  // pll and fifo enables, every bit stored
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pll_fifo_interrupt_mask_r <= irq_enable_pkg::MASK_RST;
    end else if (wr_hit(req, irq_enable_pkg::PLL_FIFO_MASK_ADDR)) begin
      pll_fifo_interrupt_mask_r <= req.wdata & irq_enable_pkg::PLL_FIFO_WR_BITS;
    end
  end

  assign fifo_fault_irq_on =
    pll_fifo_interrupt_mask_r[irq_enable_pkg::FIFO_FAULT_BIT];

  // prbs enables, upper nibble reads zero
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prbs_check_interrupt_mask_r <= irq_enable_pkg::MASK_RST;
    end else if (wr_hit(req, irq_enable_pkg::PRBS_MASK_ADDR)) begin
      prbs_check_interrupt_mask_r <= req.wdata & irq_enable_pkg::PRBS_WR_BITS;
    end
  end

  // link a enables
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      link_a_event_interrupt_mask_r <= irq_enable_pkg::MASK_RST;
    end else if (wr_hit(req, irq_enable_pkg::LINK_A_MASK_ADDR)) begin
      link_a_event_interrupt_mask_r <= req.wdata & irq_enable_pkg::LINK_WR_BITS;
    end
  end

  // link b enables
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      link_b_event_interrupt_mask_r <= irq_enable_pkg::MASK_RST;
    end else if (wr_hit(req, irq_enable_pkg::LINK_B_MASK_ADDR)) begin
      link_b_event_interrupt_mask_r <= req.wdata & irq_enable_pkg::LINK_WR_BITS;
    end
  end

  // request from any enabled flag; reserved bits never count
  always_comb begin
    irq_nxt = (fifo_fault && fifo_fault_irq_on)
      || pending(pll_fifo_status, pll_fifo_interrupt_mask_r,
                 irq_enable_pkg::PLL_FIFO_EVT_BITS)
      || pending(prbs_check_event_flags, prbs_check_interrupt_mask_r,
                 irq_enable_pkg::PRBS_EVT_BITS)
      || pending(link_a_flags, link_a_event_interrupt_mask_r,
                 irq_enable_pkg::LINK_EVT_BITS)
      || pending(link_b_flags, link_b_event_interrupt_mask_r,
                 irq_enable_pkg::LINK_EVT_BITS);
  end

  // registered interrupt request
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // read decode, unmapped offsets read zero
  always_comb begin
    unique case (req.addr)
      irq_enable_pkg::PLL_FIFO_MASK_ADDR:  rdata_nxt = pll_fifo_interrupt_mask_r;
      irq_enable_pkg::PRBS_MASK_ADDR:      rdata_nxt = prbs_check_interrupt_mask_r;
      irq_enable_pkg::LINK_A_MASK_ADDR:    rdata_nxt = link_a_event_interrupt_mask_r;
      irq_enable_pkg::LINK_B_MASK_ADDR:    rdata_nxt = link_b_event_interrupt_mask_r;
      irq_enable_pkg::PLL_FIFO_FLAGS_ADDR: rdata_nxt = pll_fifo_status;
      irq_enable_pkg::PRBS_FLAGS_ADDR:     rdata_nxt = prbs_check_event_flags;
      irq_enable_pkg::LINK_A_FLAGS_ADDR:   rdata_nxt = link_a_flags;
      irq_enable_pkg::LINK_B_FLAGS_ADDR:   rdata_nxt = link_b_flags;
      irq_enable_pkg::FIFO_FULL_ADDR:      rdata_nxt = full_seen;
      irq_enable_pkg::FIFO_EMPTY_ADDR:     rdata_nxt = empty_seen;
      default:                             rdata_nxt = '0;
    endcase
  end

  // read data one cycle after the read strobe
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata_r  <= '0;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= req.rd;
      if (req.rd) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

endmodule

// [verilog/lane_fifo_monitor.sv]
`timescale 1ns/1ns
module lane_fifo_monitor (
  // clock and reset
  input  wire logic                            mclk,
  input  wire logic                            resetn,
  // lane fifo conditions and link control
  input  wire logic [irq_enable_pkg::LANES-1:0] lane_full,
  input  wire logic [irq_enable_pkg::LANES-1:0] lane_empty,
  input  wire logic                            link_en,
  // latched per-lane state and summary
  output logic      [irq_enable_pkg::LANES-1:0] full_seen,
  output logic      [irq_enable_pkg::LANES-1:0] empty_seen,
  output logic                                 fifo_fault
);

  irq_enable_pkg::link_state_t state_r;
  logic                        reenable;

  // clear only when the link comes up again after being down
  assign reenable = (state_r == irq_enable_pkg::LINK_DOWN) && link_en;

  // link enable tracking
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_r <= irq_enable_pkg::LINK_DOWN;
    end else begin
      unique case (state_r)
        irq_enable_pkg::LINK_DOWN: if (link_en) state_r <= irq_enable_pkg::LINK_UP;
        irq_enable_pkg::LINK_UP:   if (!link_en) state_r <= irq_enable_pkg::LINK_DOWN;
      endcase
    end
  end

  // per-lane latches, a new condition wins over the clear
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      full_seen  <= '0;
      empty_seen <= '0;
    end else begin
      full_seen  <= (reenable ? '0 : full_seen) | lane_full;
      empty_seen <= (reenable ? '0 : empty_seen) | lane_empty;
    end
  end

  // summary fault on any full or empty lane
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fifo_fault <= 1'b0;
    end else begin
      fifo_fault <= (fifo_fault && !reenable) || (|lane_full) || (|lane_empty);
    end
  end

endmodule

// [verilog/sticky_flag_bank.sv]
`timescale 1ns/1ns
module sticky_flag_bank #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             resetn,
  // event pulses and write-one-to-clear
  input  wire logic [WIDTH-1:0] set_in,
  input  wire logic [WIDTH-1:0] clr_in,
  // latched flags
  output logic      [WIDTH-1:0] flags
);

  // a set in the clear cycle survives the clear
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      flags <= '0;
    end else begin
      flags <= (flags & ~clr_in) | set_in;
    end
  end

endmodule
